// ### rtl/scpd_ctrl.sv
`include "scpd_consts.svh"
// Power-good/power-down, power-up sequencer and SMBus byte-0 target
module scpd_ctrl
  import scpd_pkg::*;
#(
  parameter int DLY_CYCLES  = (`SCPD_PWRUP_DLY_US * `SCPD_CLK_MHZ),
  parameter int LOCK_CYCLES = `SCPD_LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  // Power and clock status
  input  wire logic       supply_valid,
  input  wire logic       ref_clk_in,
  input  wire logic       diff_clock_out_complement,
  input  wire logic       power_good_powerdown_pin,
  // Straps
  input  wire logic       frequency_select_strap,
  input  wire logic [1:0] pll_bandwidth_select,
  input  wire logic [1:0] target_address_select_0,
  input  wire logic [1:0] target_address_select_1,
  // SMBus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Output control
  output logic            outputs_enable,
  output logic [2:0]      output_enable_bits,
  output logic            pll_locked
);
  ////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic        pg_s, scl_s, sda_s, ref_s, cmp_s;  // Link and power pins
  logic        sup_s, freq_s;                      // Supply flag and frequency strap
  logic [1:0]  bw_s, sa0_s, sa1_s;                 // Tri-level straps
  logic [12:0] sync_in, sync_out;                  // Every pin crosses here
  // Straps and supply flag also cross, so no logic sees a raw pin
  assign sync_in = {power_good_powerdown_pin, scl_in, sda_in, ref_clk_in,
                    diff_clock_out_complement, supply_valid, frequency_select_strap,
                    pll_bandwidth_select, target_address_select_0, target_address_select_1};
  for (genvar g = 0; g < 13; g++) begin : g_sync
    scpd_sync u_sync (
      .sys_clk  (sys_clk),
      .rst_b    (rst_b),
      .async_in (sync_in[g]),
      .sync_out (sync_out[g])
    );
  end
  assign {pg_s, scl_s, sda_s, ref_s, cmp_s,
          sup_s, freq_s, bw_s, sa0_s, sa1_s} = sync_out;

  ////////////////////////////////////////////////////////////////////////
  // Strap latch on first power-good rise; bandwidth mode is resampled every cycle
  logic       pg_d_r, latched_r, freq_r;
  logic [6:0] addr_r;
  logic [1:0] mode_r;
  wire        pg_rise = pg_s & ~pg_d_r;
  // Tri-level address table (7-bit)
  function automatic logic [6:0] addr_map(input logic [1:0] s1, input logic [1:0] s0);
    logic [7:0] a;
    a = 8'hd8;
    unique case ({s1, s0})
      4'h0: a = 8'hd8;  4'h1: a = 8'hda;  4'h2: a = 8'hde;
      4'h4: a = 8'hc2;  4'h5: a = 8'hc4;  4'h6: a = 8'hc6;
      4'h8: a = 8'hca;  4'h9: a = 8'hcc;  4'ha: a = 8'hce;
      default: a = 8'hd8;
    endcase
    return a[7:1];
  endfunction
  // Mode readback from bandwidth select
  wire [1:0] mode_nxt = (bw_s == SCPD_TRI_LOW) ? 2'h0 :
                        (bw_s == SCPD_TRI_MID) ? 2'h1 : 2'h3;
  // Capture frequency and address straps once; mode follows the bandwidth strap every cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pg_d_r <= 1'b0; latched_r <= 1'b0; freq_r <= 1'b0;
      addr_r <= 7'h00; mode_r <= 2'h0;
    end else begin
      pg_d_r <= pg_s;
      mode_r <= mode_nxt;
      if (pg_rise && !latched_r) begin
        latched_r <= 1'b1;
        freq_r    <= freq_s;
        addr_r    <= addr_map(sa1_s, sa0_s);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference clock detector and lock counter
  logic       ref_d_r, cmp_d_r;
  logic [6:0] clkdet_r;
  logic [15:0] lock_r;
  wire ref_edge = ref_s & ~ref_d_r;
  wire clk_ok   = (clkdet_r != 7'h00);
  // Retrigger on each rising reference edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ref_d_r <= 1'b0; clkdet_r <= 7'h00;
    end else begin
      ref_d_r  <= ref_s;
      clkdet_r <= ref_edge ? 7'(`SCPD_CLKDET_WIN) : (clk_ok ? clkdet_r - 7'h01 : 7'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-up sequencer
  scpd_seq_type seq_r, seq_nxt;
  logic [31:0]  dly_r;
  wire pd_n = latched_r & pg_s;
  // Next-state selection
  always_comb begin
    seq_nxt = seq_r;
    unique case (seq_r)
      SCPD_ST_OFF:   if (sup_s) seq_nxt = SCPD_ST_DELAY;
      SCPD_ST_DELAY: if (dly_r == 32'(DLY_CYCLES)) seq_nxt = SCPD_ST_WAIT;
      SCPD_ST_WAIT:  if (clk_ok && pd_n && lock_r == 16'(LOCK_CYCLES))
                       seq_nxt = SCPD_ST_RUN;
      SCPD_ST_RUN:   if (!clk_ok || !pd_n) seq_nxt = SCPD_ST_WAIT;
    endcase
    if (!sup_s) seq_nxt = SCPD_ST_OFF;
  end
  // State, delay and lock counters
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      seq_r <= SCPD_ST_OFF; dly_r <= 32'h0; lock_r <= 16'h0;
    end else begin
      seq_r  <= seq_nxt;
      dly_r  <= (seq_r == SCPD_ST_DELAY) ? dly_r + 32'h1 : 32'h0;
      // Lock holds through a power-down until the outputs have stopped
      lock_r <= (!clk_ok || (!pd_n && !gate_r)) ? 16'h0 :
                (lock_r == 16'(LOCK_CYCLES)) ? lock_r : lock_r + 16'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Glitch-free power-down gating on the complement output
  logic [1:0] pd_cnt_r;
  logic       gate_r;
  wire cmp_rise = cmp_s & ~cmp_d_r;
  wire cmp_fall = ~cmp_s & cmp_d_r;
  // Count complement rises in power-down, stop on the next fall
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cmp_d_r <= 1'b0; pd_cnt_r <= 2'h0; gate_r <= 1'b0;
    end else begin
      cmp_d_r <= cmp_s;
      if (pd_n) pd_cnt_r <= 2'h0;
      else if (cmp_rise && pd_cnt_r != 2'h2) pd_cnt_r <= pd_cnt_r + 2'h1;
      // Lost clock stops at once, together with the lock flag
      if (!clk_ok) gate_r <= 1'b0;
      else if (seq_r != SCPD_ST_RUN && pd_n) gate_r <= 1'b0;
      else if (seq_r == SCPD_ST_RUN && pd_n) gate_r <= 1'b1;
      else if (pd_cnt_r == 2'h2 && cmp_fall) gate_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // SMBus target
  scpd_smb_type smb_r;
  logic       scl_d_r, sda_d_r, rd_r, last_ack_r;
  logic [2:0] bit_r;
  logic [1:0] phase_r;  // 0 addr,1 index,2 count,3 data
  logic [7:0] sh_r, idx_r;
  logic [2:0] en_r;
  logic [4:0] bc_r;
  logic [4:0] left_r;
  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  wire start_c  = scl_s & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & ~sda_d_r & sda_s;
  wire [7:0] rx_byte = {sh_r[6:0], sda_s};
  // Read data for an index; reserved bits zero
  wire [7:0] byte0 = {mode_r, en_r, 2'b00, freq_r};
  wire [7:0] rd_data = (idx_r == `SCPD_REG_BYTE0) ? byte0 :
                       (idx_r == `SCPD_REG_BYTECOUNT) ? {3'b000, bc_r} : 8'h00;
  // Protocol engine
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      smb_r <= SCPD_SM_IDLE; scl_d_r <= 1'b1; sda_d_r <= 1'b1;
      rd_r <= 1'b0; bit_r <= 3'h0; phase_r <= 2'h0; sh_r <= 8'h00;
      idx_r <= 8'h00; en_r <= `SCPD_BYTE0_EN_RST; bc_r <= `SCPD_BYTECOUNT_RST;
      left_r <= 5'h00; sda_out <= 1'b0; sda_oe <= 1'b0; last_ack_r <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (stop_c) begin
        smb_r <= SCPD_SM_IDLE; sda_oe <= 1'b0;
      end else if (start_c) begin
        smb_r <= SCPD_SM_RX; bit_r <= 3'h0; phase_r <= 2'h0; sda_oe <= 1'b0;
      end else begin
        unique case (smb_r)
          SCPD_SM_IDLE, SCPD_SM_SKIP: sda_oe <= 1'b0;
          SCPD_SM_RX: if (scl_rise) begin
            sh_r  <= rx_byte;
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7) begin
              smb_r <= SCPD_SM_RXACK;
              if (phase_r == 2'h0) begin
                rd_r <= sda_s;
                if (rx_byte[7:1] != addr_r || !latched_r) smb_r <= SCPD_SM_SKIP;
              end else if (phase_r == 2'h1) idx_r <= rx_byte;
              else if (phase_r == 2'h3) begin
                if (idx_r == `SCPD_REG_BYTE0)
                  en_r <= rx_byte[`SCPD_BYTE0_EN18:`SCPD_BYTE0_EN16];
                else if (idx_r == `SCPD_REG_BYTECOUNT)
                  bc_r <= rx_byte[4:0];
                idx_r <= idx_r + 8'h01;
              end
            end
          end
          SCPD_SM_RXACK: begin
            if (scl_fall && !sda_oe) begin
              sda_oe <= 1'b1; sda_out <= 1'b0;
            end else if (scl_fall && sda_oe) begin
              sda_oe <= 1'b0;
              if (phase_r == 2'h0 && rd_r) begin
                smb_r <= SCPD_SM_TX; sh_r <= {3'b000, bc_r}; left_r <= bc_r;
                sda_oe <= 1'b1; sda_out <= bc_r[4] & 1'b0; bit_r <= 3'h0;
              end else begin
                smb_r <= SCPD_SM_RX;
                if (phase_r != 2'h3) phase_r <= phase_r + 2'h1;
              end
            end
          end
          SCPD_SM_TX: begin
            sda_oe  <= 1'b1;
            sda_out <= sh_r[7];
            if (scl_fall) begin
              sh_r  <= {sh_r[6:0], 1'b0};
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7) begin
                smb_r <= SCPD_SM_TXACK; sda_oe <= 1'b0;
              end
            end
          end
          SCPD_SM_TXACK: if (scl_rise) last_ack_r <= sda_s;
            else if (scl_fall) begin
              if (last_ack_r || left_r == 5'h00) smb_r <= SCPD_SM_SKIP;
              else begin
                smb_r <= SCPD_SM_TX; sh_r <= rd_data; bit_r <= 3'h0;
                idx_r <= idx_r + 8'h01; left_r <= left_r - 5'h01;
              end
            end
          default: smb_r <= SCPD_SM_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      outputs_enable <= 1'b0; output_enable_bits <= `SCPD_BYTE0_EN_RST; pll_locked <= 1'b0;
    end else begin
      outputs_enable     <= gate_r;
      output_enable_bits <= en_r & {3{gate_r}};
      pll_locked         <= (lock_r == 16'(LOCK_CYCLES));
    end
  end
endmodule

// ### rtl/scpd_consts.svh
// Contract
// - Latch straps on first power-good rising edge (bandwidth strap is read every cycle, not latched)
// - Afterwards pin is asynchronous active-low power-down
// - Two low samples, then off at complement fall
// - Supply valid enters state one, waits delay
// - State two waits clock valid and power-good
// - State three enables outputs once PLL locked
// - Outputs active within 1.8 ms of power-on
// - No valid clock keeps outputs disabled
// - Block write: index, count, data, all acked
// - Each written byte acked, index increments
// - Block read returns count then bytes from index
// - Respond only to strap-selected target address
// - Byte 0 bits 7:6 report PLL mode
// - Byte 0 bits 5:3 output enables, reset one
// - Byte 0 bit 0 reports frequency strap
// - Byte count register sets read length
`ifndef SCPD_CONSTS_SVH
`define SCPD_CONSTS_SVH
`define SCPD_REG_BYTE0       8'h00
`define SCPD_REG_BYTECOUNT   8'h07
`define SCPD_BYTE0_MODE_HI   7
`define SCPD_BYTE0_MODE_LO   6
`define SCPD_BYTE0_EN18      5
`define SCPD_BYTE0_EN16      3
`define SCPD_BYTE0_FREQ      0
`define SCPD_BYTE0_EN_RST    3'h7
`define SCPD_BYTECOUNT_RST   5'h08
`define SCPD_BYTECOUNT_MASK  8'h1f
`define SCPD_PWRUP_DLY_US    100
`define SCPD_CLK_MHZ         125
`define SCPD_LOCK_CYCLES     64
`define SCPD_CLKDET_WIN      64
`endif

// ### rtl/scpd_pkg.sv
package scpd_pkg;
  // Power-up sequencer states
  typedef enum logic [1:0] {
    SCPD_ST_OFF,
    SCPD_ST_DELAY,
    SCPD_ST_WAIT,
    SCPD_ST_RUN
  } scpd_seq_type;
  // SMBus target states
  typedef enum logic [2:0] {
    SCPD_SM_IDLE,
    SCPD_SM_RX,
    SCPD_SM_RXACK,
    SCPD_SM_TX,
    SCPD_SM_TXACK,
    SCPD_SM_SKIP
  } scpd_smb_type;
  // Tri-level pin value
  typedef enum logic [1:0] {
    SCPD_TRI_LOW,
    SCPD_TRI_MID,
    SCPD_TRI_HIGH
  } scpd_tri_type;
endpackage

// ### rtl/scpd_sync.sv
// Two-flop synchroniser for an asynchronous level
module scpd_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  // Level in and out
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_r;  // First stage, read only by second

  // Two stages in series
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// ### tb/scpd_ctrl_monitor.sv
// Port-level checks on the control block
module scpd_ctrl_monitor #(
  parameter int DLY_CYCLES  = 20,
  parameter int LOCK_CYCLES = 64
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Watched ports
  input wire logic       supply_valid,
  input wire logic       ref_clk_in,
  input wire logic       power_good_powerdown_pin,
  input wire logic       scl_in,
  input wire logic       sda_oe,
  input wire logic       outputs_enable,
  input wire logic [2:0] output_enable_bits,
  input wire logic       pll_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_q_r;   // Last reference level
  logic [7:0]  idle_r;    // Cycles since a reference edge
  logic [7:0]  low_r;     // Cycles with power-down low
  logic [15:0] up_r;      // Cycles with all start conditions met
  logic [15:0] sup_r;     // Cycles with supply valid
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Helper counters
  always_ff @(posedge sys_clk) begin
    ref_q_r <= ref_clk_in;
    idle_r  <= (!rst_b || ref_q_r != ref_clk_in) ? 8'h00 : idle_r + 8'(idle_r != 8'hff);
    low_r   <= (!rst_b || power_good_powerdown_pin) ? 8'h00 : low_r + 8'(low_r != 8'hff);
    sup_r   <= (!rst_b || !supply_valid) ? 16'h0 : sup_r + 16'(sup_r != 16'hffff);
    up_r    <= (!rst_b || !supply_valid || !power_good_powerdown_pin || idle_r > 8'h3f) ?
               16'h0 : up_r + 16'(up_r != 16'hffff);
  end
  a_reset_values: assert property (disable iff (1'b0) !rst_b |=> !outputs_enable && output_enable_bits == 3'h7) else $error("reset values wrong");
  a_powerdown_input_n_off: assert property (low_r >= 8'd24 |-> !outputs_enable) else $error("outputs run in power-down");
  a_fall_cause: assert property ($fell(outputs_enable) |-> !$past(power_good_powerdown_pin, 3)) else $error("outputs stopped early");
  a_run_locked: assert property (outputs_enable |-> pll_locked) else $error("outputs run unlocked");
  a_run_needs_pin: assert property ($rose(outputs_enable) |-> power_good_powerdown_pin) else $error("outputs start in power-down");
  a_run_needs_ref: assert property ($rose(outputs_enable) |-> idle_r < 8'd64) else $error("outputs start without clock");
  a_startup_delay: assert property ($rose(outputs_enable) |-> sup_r >= DLY_CYCLES) else $error("start-up delay short");
  a_startup_bound: assert property (up_r == 16'(DLY_CYCLES + LOCK_CYCLES + 200) |-> outputs_enable) else $error("start-up too slow");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
  c_run: cover property ($rose(outputs_enable));
  c_stop: cover property ($fell(outputs_enable));
  c_ack: cover property ($rose(sda_oe));
endmodule
bind scpd_ctrl scpd_ctrl_monitor #(.DLY_CYCLES(DLY_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) u_mon (
  .sys_clk(sys_clk), .rst_b(rst_b), .supply_valid(supply_valid), .ref_clk_in(ref_clk_in),
  .power_good_powerdown_pin(power_good_powerdown_pin), .scl_in(scl_in), .sda_oe(sda_oe),
  .outputs_enable(outputs_enable), .output_enable_bits(output_enable_bits),
  .pll_locked(pll_locked));

// ### tb/scpd_host.sv
// SMBus host model; clock stands high between frames, 125 ns bit period
module scpd_host (
  // Clock and bus
  input  wire logic       sys_clk,
  input  wire logic       sda_line,
  output logic            scl,
  output logic            sda_drv,
  output logic [7:0]      got_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  event got;  // A read byte is ready
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
    got_byte = 8'h00;
  end
  // One bit: data set with the clock low, held 24 ns past the clock fall
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    #40 scl = 1'h1;
    #61 r = sda_line;
    scl = 1'h0;
    #24;
  endtask
  // Half a step off the sampling edges, so no pin moves on a clock edge
  task automatic start();
    @(negedge sys_clk);
    #0.5 sda_drv = 1'h1;
    #40 scl = 1'h1;
    #61 sda_drv = 1'h0;
    #61 scl = 1'h0;
    #24;
  endtask
  task automatic stop();
    sda_drv = 1'h0;
    #40 scl = 1'h1;
    #61 sda_drv = 1'h1;
    #61;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'h1, ack);
  endtask
  // Read a byte; NACK only the last one
  task automatic rbyte(input logic last);
    logic [7:0] b;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, b[i]);
    bit_x(last, r);
    got_byte = b;
    ->got;
  endtask
endmodule

// ### tb/scpd_ctrl_test.sv
module scpd_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_b, supply_valid, ref_clk_in, comp, pin, ref_run;
  logic scl, sda_drv, sda_oe, sda_out, oe_all, locked, ack;
  logic [2:0] oe_bits;
  logic       freq;      // Frequency strap
  logic [1:0] bw, mode;  // Bandwidth strap and its readback code
  logic [7:0] got, r;
  int n_mismatch, n_compared;
  logic [7:0] exp_q[$];  // Expected read bytes
  wire sda = sda_drv & ~(sda_oe & ~sda_out);  // Pulled-up open-drain line
  scpd_ctrl #(.DLY_CYCLES(20), .LOCK_CYCLES(64)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .supply_valid(supply_valid), .ref_clk_in(ref_clk_in),
    .diff_clock_out_complement(comp), .power_good_powerdown_pin(pin),
    .frequency_select_strap(freq), .pll_bandwidth_select(bw),
    .target_address_select_0(2'h0), .target_address_select_1(2'h0),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .outputs_enable(oe_all), .output_enable_bits(oe_bits), .pll_locked(locked));
  scpd_host h (.sys_clk(sys_clk), .sda_line(sda), .scl(scl), .sda_drv(sda_drv), .got_byte(got));
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Reference and complement clocks, still when stopped
  always @(negedge sys_clk) if (ref_run) begin
    ref_clk_in <= ~ref_clk_in;
    comp <= ref_clk_in;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Watcher of read bytes
  initial forever begin
    @(h.got);
    chk(h.got_byte, exp_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic e);
    h.wbyte(a, ack);
    chk({7'h0, ack}, {7'h0, e});
  endtask
  task automatic bwrite(input logic [7:0] idx, d0, d1, n);
    h.start();
    wr(8'hd8, 1'h0); wr(idx, 1'h0); wr(n, 1'h0);
    wr(d0, 1'h0);
    if (n == 8'h02) wr(d1, 1'h0);
    h.stop();
  endtask
  task automatic bread(input logic [7:0] idx, input int n);
    h.start();
    wr(8'hd8, 1'h0); wr(idx, 1'h0);
    h.start();
    wr(8'hd9, 1'h0);
    for (int i = 0; i <= n; i++) h.rbyte(i == n);
    h.stop();
  endtask
  task automatic wait_oe(input logic e);
    int k = 0;
    while (oe_all !== e && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    chk({7'h0, oe_all}, {7'h0, e});
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {rst_b, supply_valid, ref_clk_in, comp, pin, ref_run} = 6'h00;
    n_mismatch = 0;
    n_compared = 0;
    r = 8'($urandom(32'h508d6a2b));
    freq = r[0];
    bw = r[2:1] % 2'h3;
    mode = (bw == 2'h0) ? 2'h0 : (bw == 2'h1) ? 2'h1 : 2'h3;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'h1;
    chk({5'h0, oe_bits}, 8'h07);
    chk({7'h0, oe_all}, 8'h00);
    $display("reset test done");
    supply_valid = 1'h1;
    ref_run = 1'h1;
    repeat (5) @(negedge sys_clk);
    pin = 1'h1;
    wait_oe(1'h1);
    chk({7'h0, locked}, 8'h01);
    $display("power-up test done");
    h.start();
    wr(8'hda, 1'h1);
    h.stop();
    bwrite(8'h06, 8'h55, 8'h02, 8'h02);
    exp_q = '{8'h02, {mode, 3'h7, 2'h0, freq}, 8'h00};
    bread(8'h00, 2);
    $display("block access test done");
    r = 8'($urandom());
    bwrite(8'h00, r, 8'h00, 8'h01);
    chk({5'h0, oe_bits}, {5'h0, r[5:3]});
    exp_q = '{8'h02, {mode, r[5:3], 2'h0, freq}, 8'h00};
    bread(8'h00, 2);
    chk(8'(exp_q.size()), 8'h00);
    $display("enable test done");
    pin = 1'h0;
    wait_oe(1'h0);
    chk({5'h0, oe_bits}, 8'h00);
    ref_run = 1'h0;
    repeat (10) @(negedge sys_clk);
    pin = 1'h1;
    repeat (200) @(negedge sys_clk);
    chk({7'h0, oe_all}, 8'h00);
    ref_run = 1'h1;
    wait_oe(1'h1);
    $display("power-down test done");
    end_of_test();
  end
endmodule
